// *** rtl/ipc_gpio_cell.sv ***
// one general purpose pin: synchroniser, trigger, status flag and driver
`timescale 1ns/1ps
module ipc_gpio_cell (
   // clock and control
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // pin
   input  wire logic pin_i,
   output logic      pin_o,
   output logic      pin_oe_n,
   // configuration
   input  wire logic dir_out,
   input  wire logic pol_drive,
   input  wire logic trig_edge,
   input  wire logic out_val,
   input  wire logic rd_clr,
   // status
   output logic      status
);
   logic s1_reg;
   logic s2_reg;
   logic act_prev_reg;
   logic active;
   logic set_ev;
   logic flag;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_reg       <= 1'b0;
         s2_reg       <= 1'b0;
         act_prev_reg <= 1'b0;
         pin_o        <= 1'b0;
         pin_oe_n     <= 1'b1;
      end else if (ce) begin
         s1_reg       <= pin_i;
         s2_reg       <= s1_reg;
         act_prev_reg <= active;
         // open drain pulls low only, push-pull drives both levels
         pin_o        <= dir_out & ~pol_drive & out_val;
         pin_oe_n     <= ~dir_out | (pol_drive & out_val);
      end
   end

   assign active = pol_drive ? s2_reg : ~s2_reg;
   assign set_ev = ~dir_out & (trig_edge ? (active & ~act_prev_reg) : active);

   ipc_sticky #(.W(1)) u_flag (
      .clk   (clk),
      .rst_n (rst_n),
      .ce    (ce),
      .set   (set_ev),
      .clr   (rd_clr),
      .q     (flag)
   );

   assign status = dir_out ? out_val : flag;
endmodule

// *** rtl/ipc_irq_gpio_unit.sv ***
// interrupt aggregation and gpio configuration unit with apb register access
`timescale 1ns/1ps
// Overview of operation
// - interrupt pin style: high, low, open drain
// - clip trigger select: level or edge
// - mask bits seven to two gate their sources onto pin, gpio summary bypasses the mask
// - mask resets zero, bits seven to two
// - status bits sticky since last read
// - status read clears five edge flags
// - status read keeps clip and gpio summaries
// - detail read clears summary in edge mode
// - level mode summary held while level present
// - audio error or lock loss sets unlocked
// - locked and unlocked flags mutually exclusive
// - all channels locked raises locked flag
// - ramp done flags on all channels finished
// - mute done after all muted channels finish
// - clip summary is or of channels
// - six channel clip flags A1 to B3
// - clip flags sticky, read clears in edge
// - clip flags set regardless of mask
// - gpio summary is or of unmasked input status, pins zero to three
// - direction bit: zero input, one output
// - input polarity: zero low, one high
// - output type: zero push-pull, one open drain
// - gpio trigger: zero level, one edge
// - gpio status read clears edge status
module ipc_irq_gpio_unit (
   // clock, reset, enable
   input  wire logic                         CLK,
   input  wire logic                         RSTN,
   input  wire logic                         CE,
   // apb slave
   input  wire ipc_pkg::ipc_apb_req_t        APB_REQ,
   output ipc_pkg::ipc_apb_rsp_t             APB_RSP,
   // converter and volume status, same clock
   input  wire logic                         SRC_ALL_LOCKED,
   input  wire logic                         AUDIO_IF_ERROR,
   input  wire logic                         RAMP_UP_ALL_DONE,
   input  wire logic                         RAMP_DOWN_ALL_DONE,
   input  wire logic                         MUTE_ALL_DONE,
   input  wire logic [ipc_pkg::NUM_CLIP-1:0] CLIP_ACTIVE,
   // general purpose pins
   input  wire logic [ipc_pkg::NUM_GPIO-1:0] GPIO_I,
   output logic      [ipc_pkg::NUM_GPIO-1:0] GPIO_O,
   output logic      [ipc_pkg::NUM_GPIO-1:0] GPIO_OE_N,
   // interrupt pin
   output logic                              IRQ_O,
   output logic                              IRQ_OE_N
);
   import ipc_pkg::*;

   // ==========================================================
   // register state
   logic [7:0]          style_ctrl_reg;
   logic [7:0]          src_mask_reg;
   logic [NUM_GPIO-1:0] pin_dir_reg;
   logic [NUM_GPIO-1:0] pin_pol_reg;
   logic [NUM_GPIO-1:0] pin_trig_reg;
   logic [NUM_GPIO-1:0] pin_out_reg;
   logic [3:0]          pin_mask_reg;
   logic [7:0]          rdata_reg;
   logic [3:0]          lvl_prev_reg;
   logic [NUM_CLIP-1:0] clip_prev_reg;
   logic                irq_o_reg;
   logic                irq_oe_n_reg;

   // ==========================================================
   // apb decode
   logic       setup_ph;
   logic       access_ph;
   logic       rd_setup;
   logic       wr_take;
   logic [7:0] idx;
   logic       aligned;
   logic       hit_style;
   logic       hit_mask;
   logic       hit_flags;
   logic       hit_clip;
   logic       hit_dir;
   logic       hit_pol;
   logic       hit_trig;
   logic       hit_pstat;
   logic       hit_pmask;
   logic       mapped;
   logic [7:0] wbyte;

   assign setup_ph  = APB_REQ.psel & ~APB_REQ.penable;
   assign access_ph = APB_REQ.psel & APB_REQ.penable;
   assign rd_setup  = CE & setup_ph & ~APB_REQ.pwrite;
   assign wr_take   = CE & access_ph & APB_REQ.pwrite;
   assign idx       = APB_REQ.paddr[9:2];
   assign aligned   = APB_REQ.paddr[1:0] == 2'b00;
   assign hit_style = aligned & (idx == IDX_STYLE_CTRL);
   assign hit_mask  = aligned & (idx == IDX_SRC_MASK);
   assign hit_flags = aligned & (idx == IDX_EVENT_FLAGS);
   assign hit_clip  = aligned & (idx == IDX_CLIP_FLAGS);
   assign hit_dir   = aligned & (idx == IDX_PIN_DIR);
   assign hit_pol   = aligned & (idx == IDX_PIN_POL);
   assign hit_trig  = aligned & (idx == IDX_PIN_TRIG);
   assign hit_pstat = aligned & (idx == IDX_PIN_STATUS);
   assign hit_pmask = aligned & (idx == IDX_PIN_MASK);
   assign mapped    = hit_style | hit_mask | hit_flags | hit_clip | hit_dir |
                      hit_pol | hit_trig | hit_pstat | hit_pmask;
   assign wbyte     = APB_REQ.pwdata[7:0];

   // reads take their side effects at the capture edge so nothing slips between
   logic rd_flags;
   logic rd_clip;
   logic rd_pstat;

   assign rd_flags = rd_setup & hit_flags;
   assign rd_clip  = rd_setup & hit_clip;
   assign rd_pstat = rd_setup & hit_pstat;

   // ==========================================================
   // event detection
   logic lock_rise;
   logic lock_fall;
   logic rise_done;
   logic fall_done;
   logic mute_done;
   logic unlock_set;
   logic lock_set;

   assign lock_rise  = SRC_ALL_LOCKED & ~lvl_prev_reg[0];
   assign lock_fall  = ~SRC_ALL_LOCKED & lvl_prev_reg[0];
   assign rise_done  = RAMP_UP_ALL_DONE & ~lvl_prev_reg[1];
   assign fall_done  = RAMP_DOWN_ALL_DONE & ~lvl_prev_reg[2];
   assign mute_done  = MUTE_ALL_DONE & ~lvl_prev_reg[3];
   assign unlock_set = lock_fall | AUDIO_IF_ERROR;
   // unlock wins when both arise in one cycle
   assign lock_set   = lock_rise & ~unlock_set;

   // ==========================================================
   // edge flags: unlocked, locked, rise, fall, mute
   logic [4:0] ev_set;
   logic [4:0] ev_clr;
   logic [4:0] ev_q;

   assign ev_set = {unlock_set, lock_set, rise_done, fall_done, mute_done};
   assign ev_clr = {rd_flags | lock_set, rd_flags | unlock_set, {3{rd_flags}}};

   ipc_sticky #(.W(5)) u_events (
      .clk   (CLK),
      .rst_n (RSTN),
      .ce    (CE),
      .set   (ev_set),
      .clr   (ev_clr),
      .q     (ev_q)
   );

   // ==========================================================
   // channel clip flags, bit 0 is A1 up to bit 5 B3
   logic                clip_edge_mode;
   logic [NUM_CLIP-1:0] clip_set;
   logic [NUM_CLIP-1:0] clip_q;
   logic                clip_summary;

   assign clip_edge_mode = style_ctrl_reg[CLIP_TRIG_BIT];
   // level mode keeps setting while active, so a read only clears a gone level
   assign clip_set = clip_edge_mode ? (CLIP_ACTIVE & ~clip_prev_reg) : CLIP_ACTIVE;

   ipc_sticky #(.W(NUM_CLIP)) u_clip (
      .clk   (CLK),
      .rst_n (RSTN),
      .ce    (CE),
      .set   (clip_set),
      .clr   ({NUM_CLIP{rd_clip}}),
      .q     (clip_q)
   );

   assign clip_summary = |clip_q;

   // ==========================================================
   // general purpose pins
   logic [NUM_GPIO-1:0] pin_status;
   logic                gpio_summary;

   genvar g;
   generate
      for (g = 0; g < NUM_GPIO; g++) begin : g_pin
         ipc_gpio_cell u_cell (
            .clk       (CLK),
            .rst_n     (RSTN),
            .ce        (CE),
            .pin_i     (GPIO_I[g]),
            .pin_o     (GPIO_O[g]),
            .pin_oe_n  (GPIO_OE_N[g]),
            .dir_out   (pin_dir_reg[g]),
            .pol_drive (pin_pol_reg[g]),
            .trig_edge (pin_trig_reg[g]),
            .out_val   (pin_out_reg[g]),
            .rd_clr    (rd_pstat),
            .status    (pin_status[g])
         );
      end
   endgenerate

   assign gpio_summary = |(pin_status[3:0] & pin_mask_reg & ~pin_dir_reg[3:0]);

   // ==========================================================
   // status word and interrupt pin
   logic [7:0] flags_word;
   logic       irq_any;
   ipc_style_t style;

   assign flags_word = {ev_q, clip_summary, gpio_summary, 1'b0};
   assign irq_any    = (|(flags_word[7:2] & src_mask_reg[7:2])) | gpio_summary;
   assign style      = ipc_style_t'(style_ctrl_reg[STYLE_LSB +: 2]);

   logic irq_o_next;
   logic irq_oe_n_next;

   assign irq_o_next    = (style == STYLE_ACT_HIGH) ? irq_any :
                          (style == STYLE_ACT_LOW)  ? ~irq_any : 1'b0;
   // reserved style releases the pin instead of guessing a level
   assign irq_oe_n_next = (style == STYLE_OPEN_DRN) ? ~irq_any :
                          (style == STYLE_RESERVED) ? 1'b1 : 1'b0;

   // ==========================================================
   // read selection
   logic [7:0] rd_word;

   assign rd_word = hit_style ? {style_ctrl_reg[7:6], 5'h00, style_ctrl_reg[0]} :
                    hit_mask  ? {src_mask_reg[7:2], 2'b00} :
                    hit_flags ? flags_word :
                    hit_clip  ? {2'b00, clip_q} :
                    hit_dir   ? {1'b0, pin_dir_reg} :
                    hit_pol   ? {1'b0, pin_pol_reg} :
                    hit_trig  ? {1'b0, pin_trig_reg} :
                    hit_pstat ? {1'b0, pin_status} :
                    hit_pmask ? {4'h0, pin_mask_reg} : 8'h00;

   logic pready_w;
   logic pslverr_w;

   // zero wait states: ready in every enabled access cycle
   assign pready_w  = CE & access_ph;
   assign pslverr_w = pready_w & ~mapped;
   assign APB_RSP   = {pready_w, pslverr_w, 24'h000000, rdata_reg};

   // ==========================================================
   // register updates
   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         style_ctrl_reg <= RST_STYLE_CTRL;
         src_mask_reg   <= RST_SRC_MASK;
         pin_dir_reg    <= RST_PIN_DIR;
         pin_pol_reg    <= RST_PIN_POL;
         pin_trig_reg   <= RST_PIN_TRIG;
         pin_out_reg    <= RST_PIN_OUT;
         pin_mask_reg   <= RST_PIN_MASK;
      end else if (wr_take) begin
         if (hit_style) begin
            style_ctrl_reg <= {wbyte[7:6], 5'h00, wbyte[0]};
         end
         if (hit_mask) begin
            src_mask_reg <= {wbyte[7:2], 2'b00};
         end
         if (hit_dir) begin
            pin_dir_reg <= wbyte[6:0];
         end
         if (hit_pol) begin
            pin_pol_reg <= wbyte[6:0];
         end
         if (hit_trig) begin
            pin_trig_reg <= wbyte[6:0];
         end
         if (hit_pstat) begin
            pin_out_reg <= wbyte[6:0];
         end
         if (hit_pmask) begin
            pin_mask_reg <= wbyte[3:0];
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RSTN) begin
         rdata_reg     <= 8'h00;
         lvl_prev_reg  <= 4'h0;
         clip_prev_reg <= '0;
         irq_o_reg     <= 1'b0;
         irq_oe_n_reg  <= 1'b0;
      end else if (CE) begin
         if (rd_setup) begin
            rdata_reg <= rd_word;
         end
         lvl_prev_reg  <= {MUTE_ALL_DONE, RAMP_DOWN_ALL_DONE, RAMP_UP_ALL_DONE, SRC_ALL_LOCKED};
         clip_prev_reg <= CLIP_ACTIVE;
         irq_o_reg     <= irq_o_next;
         irq_oe_n_reg  <= irq_oe_n_next;
      end
   end

   assign IRQ_O    = irq_o_reg;
   assign IRQ_OE_N = irq_oe_n_reg;

   // ==========================================================
   // assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   a_lock_exclusive: assert property (!(ev_q[4] && ev_q[3]))
      else $error("locked and unlocked flags both set");

   a_lock_raise: assert property (
      CE && lock_rise && !AUDIO_IF_ERROR |=> ev_q[3] && !ev_q[4])
      else $error("lock edge did not raise locked flag");

   a_unlock_raise: assert property (CE && AUDIO_IF_ERROR |=> ev_q[4] && !ev_q[3])
      else $error("audio error did not raise unlocked flag");

   a_flags_clear: assert property (rd_flags && ev_set == 5'h00 |=> ev_q == 5'h00)
      else $error("status read left edge flags set");

   a_clip_keep: assert property (
      CE && rd_flags && !rd_clip |=> (clip_q & $past(clip_q)) == $past(clip_q))
      else $error("status read cleared clip flags");

   a_clip_summary: assert property (CE && clip_set != '0 |=> flags_word[BIT_CLIP_SUMMARY])
      else $error("clip summary not raised by a channel flag");

   a_level_hold: assert property (
      CE && !clip_edge_mode && CLIP_ACTIVE[0] |=> clip_q[0] [*1])
      else $error("level clip flag dropped while active");

   a_mask_gate: assert property (CE && !irq_any && style == STYLE_ACT_HIGH |=> !IRQ_O)
      else $error("interrupt pin raised with every source masked");

   a_pin_style: assert property (
      CE && style == STYLE_OPEN_DRN |=> !IRQ_O && IRQ_OE_N == !$past(irq_any))
      else $error("open drain interrupt pin wrong");

   a_pin_track: assert property (CE && irq_any && style == STYLE_ACT_LOW |=> !IRQ_O)
      else $error("active low pin did not follow sources");

   a_rise_sticky: assert property (CE && ev_q[2] && !rd_flags |=> ev_q[2])
      else $error("ramp up flag lost before a status read");

   // ==========================================================
   // scenario covers
   c_lock_then_unlock: cover property (ev_q[3] ##[1:20] ev_q[4]);
   c_clip_edge_read: cover property (clip_edge_mode && clip_summary ##1 rd_clip ##1 !clip_summary);
   c_open_drain_irq: cover property (style == STYLE_OPEN_DRN && !IRQ_OE_N);
   c_gpio_irq: cover property (gpio_summary && style == STYLE_ACT_HIGH ##1 IRQ_O);
endmodule

// *** rtl/ipc_pkg.sv ***
// shared constants, register map and carrier types of the irq and gpio configuration unit
package ipc_pkg;

   // ==========================================================
   // bus geometry
   localparam int ADDR_W    = 10;
   localparam int DATA_W    = 32;
   localparam int NUM_CLIP  = 6;
   localparam int NUM_GPIO  = 7;
   localparam int NUM_GMASK = 4;

   // ==========================================================
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_STYLE_CTRL  = 8'h28;
   localparam logic [7:0] IDX_SRC_MASK    = 8'h29;
   localparam logic [7:0] IDX_EVENT_FLAGS = 8'h2A;
   localparam logic [7:0] IDX_CLIP_FLAGS  = 8'h2B;
   localparam logic [7:0] IDX_PIN_DIR     = 8'h2C;
   localparam logic [7:0] IDX_PIN_POL     = 8'h2D;
   localparam logic [7:0] IDX_PIN_TRIG    = 8'h2E;
   localparam logic [7:0] IDX_PIN_STATUS  = 8'h2F;
   localparam logic [7:0] IDX_PIN_MASK    = 8'h30;

   // ==========================================================
   // field positions
   localparam int STYLE_LSB        = 6;
   localparam int CLIP_TRIG_BIT    = 0;
   localparam int BIT_UNLOCKED     = 7;
   localparam int BIT_LOCKED       = 6;
   localparam int BIT_RISE_DONE    = 5;
   localparam int BIT_FALL_DONE    = 4;
   localparam int BIT_MUTE_DONE    = 3;
   localparam int BIT_CLIP_SUMMARY = 2;
   localparam int BIT_GPIO_SUMMARY = 1;

   // ==========================================================
   // values after reset
   localparam logic [7:0] RST_STYLE_CTRL = 8'h00;
   localparam logic [7:0] RST_SRC_MASK   = 8'h00;
   localparam logic [6:0] RST_PIN_DIR    = 7'h00;
   localparam logic [6:0] RST_PIN_POL    = 7'h7F;
   localparam logic [6:0] RST_PIN_TRIG   = 7'h00;
   localparam logic [6:0] RST_PIN_OUT    = 7'h00;
   localparam logic [3:0] RST_PIN_MASK   = 4'h0;

   // ==========================================================
   // interrupt pin styles
   typedef enum logic [1:0] {
      STYLE_ACT_HIGH = 2'b00,
      STYLE_ACT_LOW  = 2'b01,
      STYLE_OPEN_DRN = 2'b10,
      STYLE_RESERVED = 2'b11
   } ipc_style_t;

   // ==========================================================
   // apb carriers
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } ipc_apb_req_t;

   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [DATA_W-1:0] prdata;
   } ipc_apb_rsp_t;

endpackage

// *** rtl/ipc_sticky.sv ***
// vector of sticky flags where a set beats a clear in the same cycle
`timescale 1ns/1ps
module ipc_sticky #(
   parameter int W = 1
) (
   // clock and control
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // set and clear
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   // flags
   output logic      [W-1:0] q
);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= set | (q & ~clr);
      end
   end
endmodule

// *** verif/ipc_host_model.sv ***
// host side model: interrupt wire with pull-up and gpio wire resolution
`timescale 1ns/1ps
module ipc_host_model (
   // interrupt pin and the style the host configured
   input  wire logic       irq_o,
   input  wire logic       irq_oe_n,
   input  wire logic [1:0] style,
   output logic            irq_wire,
   output logic            irq_seen,
   // general purpose pins
   input  wire logic [6:0] gpio_o,
   input  wire logic [6:0] gpio_oe_n,
   input  wire logic [6:0] ext,
   output logic      [6:0] gpio_wire
);
   // ==========================================================
   // wire levels
   // released interrupt line is held high by the board pull-up
   assign irq_wire  = irq_oe_n ? 1'h1 : irq_o;
   // host decodes an active interrupt from the configured style
   assign irq_seen  = (style == 2'h0) ? irq_wire : ((style == 2'h3) ? 1'h0 : !irq_wire);
   // a driven pin shows the device value, otherwise the outside driver
   assign gpio_wire = (gpio_o & ~gpio_oe_n) | (ext & gpio_oe_n);
endmodule

// *** verif/testbench.sv ***
// self-checking testbench of the irq and gpio configuration unit
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module testbench;
   import ipc_pkg::*;
   // ==========================================================
   // signals
   logic         CLK;
   logic         RSTN;
   logic         CE;
   ipc_apb_req_t req;
   ipc_apb_rsp_t rsp;
   logic         lock;
   logic         aerr;
   logic [2:0]   dn;
   logic [5:0]   clip;
   logic [6:0]   gext;
   logic [6:0]   gwire;
   logic [6:0]   gpio_o;
   logic [6:0]   gpio_oe_n;
   logic         irq_o;
   logic         irq_oe_n;
   logic         irq_wire;
   logic         irq_seen;
   logic [1:0]   sty;
   logic [31:0]  rdat;
   logic         perr;
   int           failures = 0;
   int           n_tests  = 0;
   int           cycles   = 0;
   localparam logic [7:0] RIDX [5] = '{IDX_STYLE_CTRL, IDX_SRC_MASK, IDX_PIN_DIR,
                                       IDX_PIN_POL, IDX_PIN_TRIG};
   localparam logic [7:0] RVAL [5] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h00};

   // ==========================================================
   // instances
   ipc_irq_gpio_unit dut (
      .CLK(CLK), .RSTN(RSTN), .CE(CE), .APB_REQ(req), .APB_RSP(rsp),
      .SRC_ALL_LOCKED(lock), .AUDIO_IF_ERROR(aerr), .RAMP_UP_ALL_DONE(dn[2]),
      .RAMP_DOWN_ALL_DONE(dn[1]), .MUTE_ALL_DONE(dn[0]), .CLIP_ACTIVE(clip),
      .GPIO_I(gwire), .GPIO_O(gpio_o), .GPIO_OE_N(gpio_oe_n),
      .IRQ_O(irq_o), .IRQ_OE_N(irq_oe_n));

   ipc_host_model host (
      .irq_o(irq_o), .irq_oe_n(irq_oe_n), .style(sty), .irq_wire(irq_wire),
      .irq_seen(irq_seen), .gpio_o(gpio_o), .gpio_oe_n(gpio_oe_n), .ext(gext),
      .gpio_wire(gwire));

   // ==========================================================
   // tasks
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge CLK);
      req.psel    <= 1'h1;
      req.penable <= 1'h0;
      req.pwrite  <= wr;
      req.paddr   <= {idx, 2'h0};
      req.pwdata  <= {24'h000000, wd};
      @(posedge CLK);
      req.penable <= 1'h1;
      @(posedge CLK);
      while (rsp.pready !== 1'h1) @(posedge CLK);
      rdat = rsp.prdata;
      perr = rsp.pslverr;
      req.psel    <= 1'h0;
      req.penable <= 1'h0;
   endtask

   task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
      apb(1'h0, idx, 8'h00);
      `CHK($sformatf("reg %0h", idx), {24'h000000, e}, rdat)
   endtask

   // ==========================================================
   // clock and timeout
   initial begin
      CLK = 1'h0;
      forever #12.5 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         finish_test();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      RSTN = 1'h0; CE = 1'h1; req = '0; lock = 1'h0; aerr = 1'h0;
      dn = 3'h0; clip = 6'h00; gext = 7'h00; sty = 2'h0;
      repeat (3) @(posedge CLK);
      RSTN <= 1'h1;
      wt(1);
      `CHK("irq_o", 1'h0, irq_o)
      `CHK("irq_oe_n", 1'h0, irq_oe_n)
      `CHK("gpio_oe_n", 7'h7F, gpio_oe_n)
      `CHK("gpio_o", 7'h00, gpio_o)
      for (int i = 0; i < 5; i++) rchk(RIDX[i], RVAL[i]);
      apb(1'h0, 8'h10, 8'h00);
      `CHK("pslverr", 1'h1, perr)
      `CHK("unmapped", 32'h00000000, rdat)
      // converter lock and unlock
      @(posedge CLK) lock <= 1'h1;
      wt(2);
      rchk(IDX_EVENT_FLAGS, 8'h40);
      rchk(IDX_EVENT_FLAGS, 8'h00);
      @(posedge CLK) lock <= 1'h0;
      @(posedge CLK) lock <= 1'h1;
      wt(2);
      rchk(IDX_EVENT_FLAGS, 8'h40);
      @(posedge CLK) aerr <= 1'h1;
      @(posedge CLK) aerr <= 1'h0;
      wt(2);
      rchk(IDX_EVENT_FLAGS, 8'h80);
      // ramp and mute completion
      for (int i = 0; i < 3; i++) begin
         @(posedge CLK) dn <= 3'h4 >> i;
         wt(2);
         rchk(IDX_EVENT_FLAGS, 8'h20 >> i);
      end
      @(posedge CLK) dn <= 3'h0;
      // clip flags, edge mode, read clear
      apb(1'h1, IDX_STYLE_CTRL, 8'h01);
      @(posedge CLK) clip <= 6'h21;
      @(posedge CLK) clip <= 6'h00;
      wt(2);
      rchk(IDX_EVENT_FLAGS, 8'h04);
      rchk(IDX_EVENT_FLAGS, 8'h04);
      rchk(IDX_CLIP_FLAGS, 8'h21);
      rchk(IDX_CLIP_FLAGS, 8'h00);
      rchk(IDX_EVENT_FLAGS, 8'h00);
      // clip flags, level mode
      apb(1'h1, IDX_STYLE_CTRL, 8'h00);
      @(posedge CLK) clip <= 6'h04;
      wt(2);
      rchk(IDX_CLIP_FLAGS, 8'h04);
      rchk(IDX_EVENT_FLAGS, 8'h04);
      `CHK("irq_masked", 1'h0, irq_seen)
      @(posedge CLK) clip <= 6'h00;
      wt(2);
      rchk(IDX_CLIP_FLAGS, 8'h04);
      rchk(IDX_EVENT_FLAGS, 8'h00);
      // interrupt pin styles
      apb(1'h1, IDX_SRC_MASK, 8'h04);
      for (int s = 0; s < 3; s++) begin
         sty = 2'(s);
         apb(1'h1, IDX_STYLE_CTRL, {sty, 6'h00});
         @(posedge CLK) clip <= 6'h01;
         wt(3);
         `CHK("irq_on", 1'h1, irq_seen)
         @(posedge CLK) clip <= 6'h00;
         rchk(IDX_CLIP_FLAGS, 8'h01);
         wt(3);
         `CHK("irq_off", 1'h0, irq_seen)
         `CHK("irq_oe_n", (s == 2), irq_oe_n)
      end
      apb(1'h1, IDX_STYLE_CTRL, 8'hFF);
      rchk(IDX_STYLE_CTRL, 8'hC1);
      wt(2);
      `CHK("irq_rsvd", 1'h1, irq_oe_n)
      apb(1'h1, IDX_STYLE_CTRL, 8'h00);
      sty = 2'h0;
      // gpio direction, polarity, trigger
      apb(1'h1, IDX_PIN_DIR, 8'h01);
      apb(1'h1, IDX_PIN_POL, 8'h76);
      apb(1'h1, IDX_PIN_TRIG, 8'h04);
      apb(1'h1, IDX_PIN_MASK, 8'h02);
      apb(1'h1, IDX_PIN_STATUS, 8'h01);
      wt(2);
      `CHK("gpio_oe_n", 7'h7E, gpio_oe_n)
      `CHK("gpio_o0", 1'h1, gpio_o[0])
      @(posedge CLK) gext <= 7'h06;
      wt(4);
      @(posedge CLK) gext <= 7'h02;
      wt(4);
      rchk(IDX_PIN_STATUS, 8'h0F);
      rchk(IDX_PIN_STATUS, 8'h0B);
      rchk(IDX_EVENT_FLAGS, 8'h02);
      rchk(IDX_EVENT_FLAGS, 8'h02);
      @(posedge CLK) gext <= 7'h00;
      wt(4);
      rchk(IDX_PIN_STATUS, 8'h0B);
      rchk(IDX_EVENT_FLAGS, 8'h00);
      // unlock source unmasked onto the pin
      apb(1'h1, IDX_SRC_MASK, 8'h80);
      @(posedge CLK) lock <= 1'h0;
      wt(3);
      `CHK("irq_unlock", 1'h1, irq_seen)
      rchk(IDX_EVENT_FLAGS, 8'h80);
      wt(2);
      `CHK("irq_cleared", 1'h0, irq_seen)
      // open drain output
      apb(1'h1, IDX_PIN_POL, 8'h77);
      wt(2);
      `CHK("od_release", 1'h1, gpio_oe_n[0])
      apb(1'h1, IDX_PIN_STATUS, 8'h00);
      wt(2);
      `CHK("od_low", 2'h0, {gpio_oe_n[0], gpio_o[0]})
      finish_test();
   end
endmodule
